// ### slp_channel.sv
// Purpose: One sink channel: ramped duty, staggered PWM, blink window
// Assumes: Phases arrive already offset for this channel
// Notes: Output enable is active low, low means sinking
`timescale 1ns/1ps
`default_nettype none
module slp_channel (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Shared timing
    input wire logic stepTick,
    input wire logic [4:0] pwmPhase,
    input wire logic [17:0] blinkPhase,
    // Configuration
    input wire slp_pkg::slp_chan_cfg_type cfg,
    input wire logic rampEnable,
    // Output
    output logic sinkOe_n,
    output logic [5:0] appliedDuty
);
    // =====================================================
    // Duty tracking
    logic [5:0] target;
    logic [5:0] applied_r;
    logic [5:0] applied_nxt;
    logic sinkOe_r;
    logic sinkOe_nxt;
    logic [17:0] periodMask;
    logic inWindow;
    logic pwmOn;

    always_comb begin
        // Codes above full scale are treated as continuously on
        target = (cfg.duty > slp_pkg::DUTY_FULL) ? slp_pkg::DUTY_FULL : cfg.duty;
        applied_nxt = applied_r;
        if (!rampEnable || cfg.blink != slp_pkg::BLINK_NONE) begin
            applied_nxt = target;
        end else if (stepTick) begin
            if (applied_r < target) begin
                applied_nxt = applied_r + 6'h01;
            end else if (applied_r > target) begin
                applied_nxt = applied_r - 6'h01;
            end
        end
    end

    // =====================================================
    // Waveform
    always_comb begin
        unique case (cfg.blink)
            slp_pkg::BLINK_1S: periodMask = slp_pkg::PERIOD_1S_MASK;
            slp_pkg::BLINK_4S: periodMask = slp_pkg::PERIOD_4S_MASK;
            slp_pkg::BLINK_8S: periodMask = slp_pkg::PERIOD_8S_MASK;
            default: periodMask = 18'h00000;
        endcase
        // Blink lowers repetition rate; half-second on window per period
        inWindow = (cfg.blink == slp_pkg::BLINK_NONE)
            || ((blinkPhase & periodMask) < slp_pkg::HALF_SEC_REF);
        pwmOn = ({1'h0, pwmPhase} < applied_r);
        sinkOe_nxt = !(inWindow && pwmOn && cfg.level != slp_pkg::LEVEL_OFF);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            applied_r <= slp_pkg::DUTY_FULL;
            sinkOe_r <= 1'h1;
        end else begin
            applied_r <= applied_nxt;
            sinkOe_r <= sinkOe_nxt;
        end
    end

    assign sinkOe_n = sinkOe_r;
    assign appliedDuty = applied_r;
endmodule
`default_nettype wire

// ### slp_led_load.sv
// Purpose: Open-drain load on the six sink pins
// Assumes: Pull-up on every pin
// Notes: Released pin reads high, never the last driven value
`timescale 1ns/1ps
`default_nettype none
module slp_led_load (
    // Sink enables from the block
    input wire logic [5:0] sinkOe_n,
    // Pin level seen by the load
    output logic [5:0] pinLevel
);
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            pinLevel[i] = sinkOe_n[i] ? 1'b1 : 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### slp_pkg.sv
// Purpose: Shared constants and types for the status LED PWM block
// Assumes: 125 MHz clk, 32.768 kHz reference made internally
// Notes: Register offsets are 9-bit byte addresses
package slp_pkg;
    localparam int NUM_CH = 6;
    localparam int ADDR_W = 9;
    // =====================================================
    // Register map
    localparam logic [8:0] BANK_A_OFFS = 9'h025;
    localparam logic [8:0] BANK_B_OFFS = 9'h026;
    localparam logic [8:0] BANK_C_OFFS = 9'h027;
    localparam logic [8:0] ADV_BASE_OFFS = 9'h1d6;
    localparam logic [7:0] BANK_RESET = 8'h00;
    localparam logic [7:0] ADV_RESET = 8'hfc;
    // Bank field positions (two channels per bank register)
    localparam int LEVEL_LO_POS = 0;
    localparam int BLINK_LO_POS = 2;
    localparam int LEVEL_HI_POS = 4;
    localparam int BLINK_HI_POS = 6;
    // Advanced register field positions
    localparam int ADV_BLINK_POS = 0;
    localparam int ADV_DUTY_POS = 2;
    // =====================================================
    // Codes
    localparam logic [1:0] BLINK_NONE = 2'h0;
    localparam logic [1:0] BLINK_1S = 2'h1;
    localparam logic [1:0] BLINK_4S = 2'h2;
    localparam logic [1:0] BLINK_8S = 2'h3;
    localparam logic [1:0] LEVEL_OFF = 2'h0;
    localparam logic [5:0] DUTY_FULL = 6'h20;
    // =====================================================
    // Timing
    localparam int CLK_HZ = 125000000;
    localparam int REF_HZ = 32768;
    localparam int REF_DIV = CLK_HZ / REF_HZ;
    localparam logic [11:0] REF_DIV_LAST = 12'(REF_DIV - 1);
    localparam int PWM_SLOTS = 32;
    localparam int RAMP_STEP_REF = REF_HZ / 64;
    localparam logic [8:0] RAMP_STEP_LAST = 9'(RAMP_STEP_REF - 1);
    localparam int BLINK_CNT_W = 18;
    // Blink periods in ref cycles, all powers of two
    localparam logic [17:0] PERIOD_1S_MASK = 18'h07fff;
    localparam logic [17:0] PERIOD_4S_MASK = 18'h1ffff;
    localparam logic [17:0] PERIOD_8S_MASK = 18'h3ffff;
    localparam logic [17:0] HALF_SEC_REF = 18'(REF_HZ / 2);

    typedef struct packed {
        logic [1:0] level;
        logic [1:0] blink;
        logic [5:0] duty;
    } slp_chan_cfg_type;
endpackage

// ### slp_status_led.sv
// Purpose: Six-channel signaling LED sink controller with ramp and blink
// Assumes: Register port is driven by the serial interface on clk
// Notes: Ramp enables are plain inputs; they have no register offset
// Operation
// - Six sink channels in two RGB banks, each independent.
// - Two-bit level per channel, zero means no current.
// - Six-bit duty code per channel sets on fraction.
// - Each channel's PWM offset by one reference cycle from the next.
// - Per-channel ramp enable selects ramped duty changes.
// - Ramp moves applied duty one thirty-second every sixty-fourth second.
// - Every duty change starts a ramp, up or down, when enabled.
// - Ramp disabled applies new duty immediately.
// - Two-bit blink selector: none, 1, 4 or 8 seconds.
// - Blink lowers repetition rate, half-second default on time.
// - While blinking, no ramp is applied; duty still sets the on fraction.
// - Outputs usable as open-drain logic or generic PWM.
// - Bank register 0x25 resets to zero, red and green fields.
// - Bank register 0x26 holds blue A fields and red B level and blink.
// - Duty in thirty-seconds, 0x20 continuous, above that don't care.
// - Blink 00 enables advanced duty control, default full on.
// - Non-zero blink returns channel to fixed half-second on time.
`timescale 1ns/1ps
`default_nettype none
module slp_status_led (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [8:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    // Ramp control
    input wire logic [5:0] rampEnable,
    // Sink outputs: red A, green A, blue A, red B, green B, blue B
    output logic [5:0] sinkOe_n,
    output logic [11:0] sinkLevel
);
    // =====================================================
    // Configuration storage
    slp_pkg::slp_chan_cfg_type cfg_r [slp_pkg::NUM_CH];
    slp_pkg::slp_chan_cfg_type cfg_nxt [slp_pkg::NUM_CH];
    logic [7:0] rdData_r;
    logic [7:0] rdData_nxt;
    logic [11:0] level_r;
    logic [11:0] level_nxt;

    // Bank register index for an address, 3 when not a bank register
    function automatic logic [1:0] bank_index(input logic [8:0] a);
        if (a == slp_pkg::BANK_A_OFFS) return 2'h0;
        if (a == slp_pkg::BANK_B_OFFS) return 2'h1;
        if (a == slp_pkg::BANK_C_OFFS) return 2'h2;
        return 2'h3;
    endfunction

    // Advanced register hit for a channel
    function automatic logic adv_hit(input logic [8:0] a, input int ch);
        return a == 9'(slp_pkg::ADV_BASE_OFFS + 9'(ch));
    endfunction

    // Bank view of a channel pair, low channel in the low nibble
    function automatic logic [7:0] bank_word(
        input slp_pkg::slp_chan_cfg_type lo,
        input slp_pkg::slp_chan_cfg_type hi
    );
        return {hi.blink, hi.level, lo.blink, lo.level};
    endfunction

    // Reset view; struct order differs from the advanced register layout
    function automatic slp_pkg::slp_chan_cfg_type chan_reset();
        slp_pkg::slp_chan_cfg_type c;
        c.level = slp_pkg::BANK_RESET[slp_pkg::LEVEL_LO_POS +: 2];
        c.blink = slp_pkg::ADV_RESET[slp_pkg::ADV_BLINK_POS +: 2];
        c.duty = slp_pkg::ADV_RESET[slp_pkg::ADV_DUTY_POS +: 6];
        return c;
    endfunction

    // =====================================================
    // Register writes
    always_comb begin
        logic [1:0] bank;
        bank = bank_index(regAddr);
        for (int i = 0; i < slp_pkg::NUM_CH; i++) begin
            cfg_nxt[i] = cfg_r[i];
            // Blink field is shared between bank and advanced views
            if (regWrEn && bank == 2'(i / 2)) begin
                if (i % 2 == 0) begin
                    cfg_nxt[i].level = regWrData[slp_pkg::LEVEL_LO_POS +: 2];
                    cfg_nxt[i].blink = regWrData[slp_pkg::BLINK_LO_POS +: 2];
                end else begin
                    cfg_nxt[i].level = regWrData[slp_pkg::LEVEL_HI_POS +: 2];
                    cfg_nxt[i].blink = regWrData[slp_pkg::BLINK_HI_POS +: 2];
                end
            end
            if (regWrEn && adv_hit(regAddr, i)) begin
                cfg_nxt[i].blink = regWrData[slp_pkg::ADV_BLINK_POS +: 2];
                cfg_nxt[i].duty = regWrData[slp_pkg::ADV_DUTY_POS +: 6];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < slp_pkg::NUM_CH; i++) begin
                cfg_r[i] <= chan_reset();
            end
        end else begin
            for (int i = 0; i < slp_pkg::NUM_CH; i++) begin
                cfg_r[i] <= cfg_nxt[i];
            end
        end
    end

    // =====================================================
    // Level outputs move on the write edge, not one clock later
    always_comb begin
        for (int i = 0; i < slp_pkg::NUM_CH; i++) begin
            level_nxt[2*i +: 2] = cfg_nxt[i].level;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            level_r <= 12'h000;
        end else begin
            level_r <= level_nxt;
        end
    end

    // =====================================================
    // Register reads; data holds until the next read strobe
    always_comb begin
        logic [1:0] rdBank;
        rdBank = bank_index(regAddr);
        rdData_nxt = rdData_r;
        if (regRdEn) begin
            // Unmapped addresses read as zero
            rdData_nxt = 8'h00;
            for (int b = 0; b < slp_pkg::NUM_CH / 2; b++) begin
                if (rdBank == 2'(b)) begin
                    rdData_nxt = bank_word(cfg_r[2*b], cfg_r[2*b+1]);
                end
            end
            for (int i = 0; i < slp_pkg::NUM_CH; i++) begin
                if (adv_hit(regAddr, i)) begin
                    rdData_nxt = {cfg_r[i].duty, cfg_r[i].blink};
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdData_r <= 8'h00;
        end else begin
            rdData_r <= rdData_nxt;
        end
    end

    assign regRdData = rdData_r;
    assign sinkLevel = level_r;

    // =====================================================
    // Reference timebase
    // Divider drops its remainder, so the reference runs slightly fast
    logic [11:0] div_r;
    logic [11:0] div_nxt;
    logic [4:0] pwmCnt_r;
    logic [4:0] pwmCnt_nxt;
    logic [8:0] stepCnt_r;
    logic [8:0] stepCnt_nxt;
    logic [17:0] blinkCnt_r;
    logic [17:0] blinkCnt_nxt;
    logic refTick;
    logic stepTick;

    always_comb begin
        refTick = (div_r == slp_pkg::REF_DIV_LAST);
        stepTick = refTick && (stepCnt_r == slp_pkg::RAMP_STEP_LAST);
        div_nxt = refTick ? 12'h000 : div_r + 12'h001;
        pwmCnt_nxt = refTick ? pwmCnt_r + 5'h01 : pwmCnt_r;
        stepCnt_nxt = refTick ? stepCnt_r + 9'h001 : stepCnt_r;
        blinkCnt_nxt = refTick ? blinkCnt_r + 18'h00001 : blinkCnt_r;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            div_r <= 12'h000;
            pwmCnt_r <= 5'h00;
            stepCnt_r <= 9'h000;
            blinkCnt_r <= 18'h00000;
        end else begin
            div_r <= div_nxt;
            pwmCnt_r <= pwmCnt_nxt;
            stepCnt_r <= stepCnt_nxt;
            blinkCnt_r <= blinkCnt_nxt;
        end
    end

    // =====================================================
    // Channels; one reference cycle of skew keeps edges apart
    genvar g;
    generate
        for (g = 0; g < slp_pkg::NUM_CH; g++) begin : gen_ch
            slp_channel u_ch (
                .clk(clk),
                .reset_n(reset_n),
                .stepTick(stepTick),
                .pwmPhase(5'(pwmCnt_r - 5'(g))),
                .blinkPhase(18'(blinkCnt_r - 18'(g))),
                .cfg(cfg_r[g]),
                .rampEnable(rampEnable[g]),
                .sinkOe_n(sinkOe_n[g]),
                .appliedDuty()
            );
        end
    endgenerate
endmodule
`default_nettype wire

// ### slp_status_led_chk.sv
// Purpose: Port assertions for the status LED sink block
// Assumes: One clk domain, synchronous active-low reset
// Notes: Output latency slack of a few clocks is allowed
`timescale 1ns/1ps
`default_nettype none
module slp_status_led_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [8:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    // Sink side
    input wire logic [5:0] rampEnable,
    input wire logic [5:0] sinkOe_n,
    input wire logic [11:0] sinkLevel
);
    // ====================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    reset_values_a: assert property (disable iff (1'h0) !reset_n |=>
        sinkOe_n == 6'h3f && sinkLevel == 12'h000 && regRdData == 8'h00) else $error("reset value");
    zero_level_a: assert property ((sinkLevel[1:0] == 2'h0)[*3] |-> sinkOe_n[0])
        else $error("sink on at level zero");
    zero_level_last_a: assert property ((sinkLevel[11:10] == 2'h0)[*3] |-> sinkOe_n[5])
        else $error("last sink on at level zero");
    bank_a_write_a: assert property (regWrEn && regAddr == slp_pkg::BANK_A_OFFS |=>
        sinkLevel[3:0] == {$past(regWrData[5:4]), $past(regWrData[1:0])}) else $error("bank a");
    bank_b_write_a: assert property (regWrEn && regAddr == slp_pkg::BANK_B_OFFS |=>
        sinkLevel[7:4] == {$past(regWrData[5:4]), $past(regWrData[1:0])}) else $error("bank b");
    bank_c_write_a: assert property (regWrEn && regAddr == slp_pkg::BANK_C_OFFS |=>
        sinkLevel[11:8] == {$past(regWrData[5:4]), $past(regWrData[1:0])}) else $error("bank c");
    unmapped_read_a: assert property (regRdEn && regAddr == 9'h100 |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    read_hold_a: assert property (!regRdEn |=> $stable(regRdData))
        else $error("read data moved without read");
    duty_now_a: assert property (regWrEn && regAddr == slp_pkg::ADV_BASE_OFFS &&
        regWrData[7:2] == 6'h00 && !rampEnable[0] |-> ##[1:4] sinkOe_n[0]) else $error("duty late");
    blink_noramp_a: assert property (regWrEn && regAddr == slp_pkg::ADV_BASE_OFFS + 9'h001 &&
        regWrData == 8'h01 |-> ##[1:4] sinkOe_n[1]) else $error("ramp while blinking");
    // Main scenarios
    bank_a_c: cover property (regWrEn && regAddr == slp_pkg::BANK_A_OFFS);
    duty_now_c: cover property (regWrEn && regAddr == slp_pkg::ADV_BASE_OFFS && !rampEnable[0]);
    unmapped_c: cover property (regRdEn && regAddr == 9'h100);
    bank_c_c: cover property (regWrEn && regAddr == slp_pkg::BANK_C_OFFS);
endmodule
`default_nettype wire

// ### status_led_pwm_ramp_blink_bench.sv
// Purpose: Self-checking bench for the status LED sink block
// Assumes: Inputs driven on the falling edge
// Notes: Ramp steps are too slow to finish; only the hold is seen
`timescale 1ns/1ps
`default_nettype none
module status_led_pwm_ramp_blink_bench;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic [8:0] regAddr = 9'h000;
    logic [7:0] regWrData = 8'h00;
    logic regWrEn = 1'h0;
    logic regRdEn = 1'h0;
    logic [5:0] rampEnable = 6'h00;
    logic [7:0] regRdData;
    logic [5:0] sinkOe_n;
    logic [5:0] pinLevel;
    logic [11:0] sinkLevel;
    logic rdLate = 1'h0;
    logic [7:0] rdExp[$];
    logic [1:0] lvl;
    int errorCnt = 0;
    int nChecks = 0;
    int waitCnt;
    initial forever #4 clk = ~clk;
    slp_status_led i_dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .rampEnable(rampEnable), .sinkOe_n(sinkOe_n), .sinkLevel(sinkLevel));
    slp_led_load i_load (.sinkOe_n(sinkOe_n), .pinLevel(pinLevel));
    // ====================
    // Tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'h1;
        @(negedge clk);
        regWrEn = 1'h0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(negedge clk);
        regAddr = a;
        regRdEn = 1'h1;
        rdExp.push_back(exp);
        @(negedge clk);
        regRdEn = 1'h0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic reportAndStop();
        $display("checks %0d, errors %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Read data lands one clock after the strobe
    always @(posedge clk) rdLate <= regRdEn;
    always @(negedge clk) begin
        if (rdLate && rdExp.size() > 0) begin
            check("regRdData", 32'(regRdData), 32'(rdExp.pop_front()));
        end
    end
    // Half-period wait dominates the run time
    initial begin
        #(8 * 95000);
        errorCnt++;
        reportAndStop();
    end
    initial begin
        void'($urandom(18));
        settle(3);
        reset_n = 1'h1;
        rd(slp_pkg::BANK_A_OFFS, 8'h00);
        for (int i = 0; i < 6; i++) begin
            rd(slp_pkg::ADV_BASE_OFFS + 9'(i), slp_pkg::ADV_RESET);
        end
        rd(9'h100, 8'h00);
        for (int c = 0; c < 4; c++) begin
            lvl = 2'($urandom);
            wr(slp_pkg::BANK_B_OFFS, {2'h0, lvl, 2'h0, 2'(c)});
            check("sinkLevel", 32'(sinkLevel[7:4]), 32'({lvl, 2'(c)}));
            rd(slp_pkg::BANK_B_OFFS, {2'h0, lvl, 2'h0, 2'(c)});
        end
        // Early in the run blue B's blink phase still lags into the closed window
        wr(slp_pkg::BANK_C_OFFS, 8'h70);
        wr(slp_pkg::BANK_A_OFFS, 8'h0b);
        settle(4);
        check("pinLevel", 32'(pinLevel[5]), 32'h1);
        check("pinLevel", 32'(pinLevel[0]), 32'h0);
        rd(slp_pkg::BANK_C_OFFS, 8'h70);
        wr(slp_pkg::BANK_A_OFFS, 8'h0f);
        settle(4);
        check("pinLevel", 32'(pinLevel[0]), 32'h0);
        wr(slp_pkg::BANK_A_OFFS, 8'h33);
        settle(4);
        check("pinLevel", 32'(pinLevel[1:0]), 32'h0);
        wr(slp_pkg::ADV_BASE_OFFS, 8'h00);
        settle(4);
        check("pinLevel", 32'(pinLevel[0]), 32'h1);
        wr(slp_pkg::ADV_BASE_OFFS, 8'h80);
        settle(4);
        check("pinLevel", 32'(pinLevel[0]), 32'h0);
        rampEnable = {4'($urandom), 2'h2};
        wr(slp_pkg::ADV_BASE_OFFS + 9'h001, 8'h00);
        settle(1000);
        check("pinLevel", 32'(pinLevel[1]), 32'h0);
        wr(slp_pkg::ADV_BASE_OFFS + 9'h001, 8'h01);
        settle(4);
        check("pinLevel", 32'(pinLevel[1]), 32'h1);
        rd(slp_pkg::BANK_A_OFFS, 8'h73);
        rampEnable = 6'h00;
        wr(slp_pkg::ADV_BASE_OFFS + 9'h001, 8'h40);
        wr(slp_pkg::ADV_BASE_OFFS, 8'h40);
        settle(5);
        lvl = pinLevel[1:0];
        waitCnt = 0;
        while (pinLevel[0] === lvl[0] && waitCnt < 70000) begin
            @(negedge clk);
            waitCnt++;
        end
        check("halfPeriod", 32'(waitCnt <= (slp_pkg::PWM_SLOTS / 2) * slp_pkg::REF_DIV + 4),
            32'h1);
        lvl = pinLevel[1:0];
        waitCnt = 0;
        while (pinLevel[1] === lvl[1] && waitCnt < 5000) begin
            @(negedge clk);
            waitCnt++;
        end
        check("stagger", 32'(waitCnt), 32'(slp_pkg::REF_DIV));
        waitCnt = 0;
        while (pinLevel[5] === 1'h1 && waitCnt < 6 * slp_pkg::REF_DIV) begin
            @(negedge clk);
            waitCnt++;
        end
        check("pinLevel", 32'(pinLevel[5]), 32'h0);
        reportAndStop();
    end
endmodule
bind slp_status_led slp_status_led_chk i_chk (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .rampEnable(rampEnable), .sinkOe_n(sinkOe_n), .sinkLevel(sinkLevel));
`default_nettype wire
